// File: cal_loader_pkg.sv
package cal_loader_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ       = 20_000_000;
  localparam int unsigned REFRESH_MS     = 4;
  localparam int unsigned REFRESH_CYCLES = REFRESH_MS * (CLOCK_HZ / 1000);
  localparam int unsigned LISTEN_MS      = 10;
  localparam int unsigned LISTEN_CYCLES  = LISTEN_MS * (CLOCK_HZ / 1000);
  localparam int unsigned INIT_SPAN_BITS = 9;

  // ----------------------------------------------------------------
  // flash map
  // ----------------------------------------------------------------
  localparam int unsigned FLASH_BYTES       = 2048;
  localparam int unsigned PAGE_BYTES        = 512;
  localparam logic [10:0] OFFSET_TABLE_BASE = 11'h000;
  localparam logic [10:0] OFFSET_TABLE_END  = 11'h15f;
  localparam logic [10:0] SPAN_TABLE_BASE   = 11'h200;
  localparam logic [10:0] SPAN_TABLE_END    = 11'h35f;
  localparam logic [10:0] OFFSET_TC_ADDR    = 11'h380;
  localparam logic [10:0] SPAN_TC_ADDR      = 11'h382;
  localparam logic [10:0] FIRST_CONFIG_WORD_ADDR      = 11'h384;
  localparam logic [10:0] SECOND_CONFIG_WORD_ADDR      = 11'h386;
  localparam logic [7:0]  INDEX_MAX         = 8'haf;

  // ----------------------------------------------------------------
  // calibration word ids and config fields
  // ----------------------------------------------------------------
  localparam logic [2:0] W_OFFSET  = 3'h0;
  localparam logic [2:0] W_SPAN    = 3'h1;
  localparam logic [2:0] W_OFF_TC  = 3'h2;
  localparam logic [2:0] W_SPAN_TC = 3'h3;
  localparam logic [2:0] W_CFG1    = 3'h4;
  localparam logic [2:0] W_CFG2    = 3'h5;
  localparam int unsigned FAULT_EN_BIT = 6;
  localparam int unsigned MIRROR_LSB   = 0;
  localparam int unsigned REFRATE_LSB  = 8;

  // ----------------------------------------------------------------
  // serial command targets
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_DATA3     = 4'h3;
  localparam logic [3:0] CMD_LOAD      = 4'h4;
  localparam logic [3:0] CMD_GO_ANALOG = 4'h5;

  // ----------------------------------------------------------------
  // register bus map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_TRIMS   = 8'h08;
  localparam logic [7:0] REG_TEMPCO  = 8'h0c;
  localparam logic [7:0] REG_CONFIG  = 8'h10;
  localparam int unsigned CTL_RELOAD    = 0;
  localparam int unsigned CTL_ERASE     = 1;
  localparam int unsigned CTL_PAGE_LSB  = 2;
  localparam int unsigned CTL_FERR_CLR  = 4;

  typedef enum logic [3:0] {
    S_LISTEN = 4'b0001,
    S_CAL    = 4'b0010,
    S_LOAD   = 4'b0100,
    S_RUN    = 4'b1000
  } load_state_t;

  typedef enum logic [5:0] {
    RX_INIT  = 6'b000001,
    RX_MEAS  = 6'b000010,
    RX_IDLE  = 6'b000100,
    RX_START = 6'b001000,
    RX_DATA  = 6'b010000,
    RX_STOP  = 6'b100000
  } rx_state_t;

  typedef struct packed {
    logic [15:0] second_config_word;
    logic [15:0] first_config_word;
    logic [15:0] span_tempco_word;
    logic [15:0] offset_tempco_word;
    logic [15:0] span_trim_word;
    logic [15:0] offset_trim_word;
  } calibration_words_t;

  typedef struct packed {
    logic        rd;
    logic [10:0] addr;
    logic        erase;
    logic [1:0]  page;
  } flash_req_t;

endpackage

// File: temp_indexed_cal_loader.sv
// Overview of operation
// RL1 - span trims come from 176-entry word table
// RL2 - temperature sampled periodically into 8-bit index
// RL3 - index saturates at 0x00 and 0xaf
// RL4 - index picks which trim entries are fetched
// RL5 - offset table 0x000-0x15f, span 0x200-0x35f
// RL6 - each word built from two flash bytes
// RL7 - four 512-byte pages, erased one at once
// RL8 - tempco and config words from fixed addresses
// RL9 - host leaves bytes 0x400/0x401 untouched
// RL10 - six words loaded from flash or serial
// RL11 - listen timeout: analog mode, full flash load
// RL12 - refresh timer reloads index and trim words
// RL13 - serial activity while listening: calibration mode
// RL14 - go-analog command reloads all words from flash
// RL15 - enabled fault detect flags out-of-window inputs
// RL16 - fault in analog mode clips output low
// RL17 - first config word selects mirror ratio
// RL18 - bit rate measured from initialization byte
// RL19 - 8N1 characters, accepted only in digital mode
// RL20 - init byte 01h timed start to stop
// RL21 - host waits 2ms before init byte
// RL22 - command byte: low nibble target, high value
// RL23 - table address base plus twice index
// RL24 - low stop bit discards the character
`timescale 1ns/1ps
`default_nettype none

module temp_indexed_cal_loader
  import cal_loader_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES_P = REFRESH_CYCLES,
  parameter int unsigned LISTEN_CYCLES_P  = LISTEN_CYCLES
) (
  input  wire logic               clock_i,
  input  wire logic               rst_b_i,
  input  wire logic [7:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic               shared_output_pin_i,
  output logic                    shared_output_pin_o,
  output logic                    shared_output_pin_oe_o,
  input  wire logic signed [9:0]  temp_code_i,
  input  wire logic [1:0]         sensor_below_i,
  input  wire logic [1:0]         sensor_above_i,
  input  wire logic [7:0]         flash_data_i,
  output flash_req_t              flash_o,
  output calibration_words_t      calibration_words_o,
  output logic      [7:0]         temperature_table_index_o,
  output logic      [1:0]         bridge_mirror_ratio_o,
  output logic                    analog_mode_o,
  output logic                    fault_o,
  output logic                    clip_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  load_state_t       st_q, st_d;
  logic [2:0]        item_q, item_d, last_q, last_d;
  logic [1:0]        step_q, step_d;
  logic [7:0]        low_q, low_d, index_q, index_d, temp_sat;
  logic [5:0][15:0]  words_q, words_d;
  logic [15:0]       data_q, data_d;
  logic [19:0]       refr_q, refr_d, listen_q, listen_d, refr_limit;
  flash_req_t        flash_q, flash_d;
  logic              fault_q, fault_d, clip_q, clip_d, analog_q, analog_d;
  rx_state_t         rx_q, rx_d;
  logic [19:0]       cnt_q, cnt_d;
  logic [15:0]       period_q, period_d;
  logic [2:0]        bit_q, bit_d;
  logic [7:0]        shift_q, shift_d, cmd_q, cmd_d;
  logic              cmd_valid_q, cmd_valid_d, pin_q, rises_q, rises_d;
  logic              ferr_q, ferr_d, rx_en, pin_fall, pin_rise;
  logic              wait_q, wait_d, bus_req, bus_take, ctl_write;
  logic [31:0]       rdata_q, rdata_d;
  logic [10:0]       word_addr;

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  // one wait cycle per access; effects happen at the releasing edge
  assign bus_req   = avs_read_i | avs_write_i;
  assign bus_take  = bus_req & ~wait_q;
  assign ctl_write = bus_take & avs_write_i & (avs_address_i == REG_CONTROL);

  // decode during the wait cycle so data stands at the take edge
  always_comb begin
    wait_d  = ~(bus_req & wait_q);
    rdata_d = rdata_q;
    if (bus_req && wait_q && avs_read_i) begin
      if (avs_address_i == REG_STATUS) begin
        rdata_d = {16'h0, index_q, 3'h0, ferr_q, st_q == S_LOAD, fault_q, st_q == S_CAL, analog_q};
      end else if (avs_address_i == REG_TRIMS) begin
        rdata_d = {words_q[W_SPAN], words_q[W_OFFSET]};
      end else if (avs_address_i == REG_TEMPCO) begin
        rdata_d = {words_q[W_SPAN_TC], words_q[W_OFF_TC]};
      end else if (avs_address_i == REG_CONFIG) begin
        rdata_d = {words_q[W_CFG2], words_q[W_CFG1]};
      end else begin
        rdata_d = 32'h0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // temperature index and flash addressing
  // ----------------------------------------------------------------
  // RL3 saturate index
  // RL1 limits lookups to 176 entries
  always_comb begin
    if (temp_code_i < 10'sd0) begin
      temp_sat = 8'h00;
    end else if (temp_code_i > $signed({2'b00, INDEX_MAX})) begin
      temp_sat = INDEX_MAX;
    end else begin
      temp_sat = temp_code_i[7:0];
    end
  end

  // RL5 table windows start at package bases
  // RL23 base plus twice index, low byte even
  // RL8 fixed homes for tempco and config
  always_comb begin
    case (item_q)
      W_OFFSET:  word_addr = OFFSET_TABLE_BASE + {2'b00, index_q, 1'b0};
      W_SPAN:    word_addr = SPAN_TABLE_BASE + {2'b00, index_q, 1'b0};
      W_OFF_TC:  word_addr = OFFSET_TC_ADDR;
      W_SPAN_TC: word_addr = SPAN_TC_ADDR;
      W_CFG1:    word_addr = FIRST_CONFIG_WORD_ADDR;
      default:   word_addr = SECOND_CONFIG_WORD_ADDR;
    endcase
  end

  // refresh period scales with the rate field of the second word
  assign refr_limit = 20'(REFRESH_CYCLES_P) * (20'(words_q[W_CFG2][REFRATE_LSB +: 2]) + 20'h1);

  // ----------------------------------------------------------------
  // mode and loader state machine
  // ----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    item_d   = item_q;
    step_d   = step_q;
    last_d   = last_q;
    low_d    = low_q;
    words_d  = words_q;
    index_d  = index_q;
    refr_d   = refr_q;
    listen_d = listen_q;
    data_d   = data_q;
    flash_d  = '0;
    // RL7 erase one selected page
    if (ctl_write && avs_writedata_i[CTL_ERASE] && st_q != S_LOAD) begin
      flash_d.erase = 1'b1;
      flash_d.page  = avs_writedata_i[CTL_PAGE_LSB +: 2];
    end
    case (st_q)
      S_LISTEN: begin
        // RL13 activity keeps calibration mode
        if (pin_fall) begin
          st_d = S_CAL;
        // RL11 timeout loads all six words
        end else if (listen_q == 20'(LISTEN_CYCLES_P - 1)) begin
          st_d    = S_LOAD;
          index_d = temp_sat;
          item_d  = W_OFFSET;
          step_d  = 2'h0;
          last_d  = W_CFG2;
        end else begin
          listen_d = listen_q + 20'h1;
        end
      end
      S_CAL: begin
        // RL22 target nibble then value nibble
        if (cmd_valid_q) begin
          if (cmd_q[3:0] <= CMD_DATA3) begin
            data_d[cmd_q[1:0] * 4 +: 4] = cmd_q[7:4];
          // RL10 serial load of one word
          end else if (cmd_q[3:0] == CMD_LOAD && cmd_q[6:4] <= W_CFG2) begin
            words_d[cmd_q[6:4]] = data_q;
          // RL14 reload everything on entry
          end else if (cmd_q[3:0] == CMD_GO_ANALOG) begin
            st_d    = S_LOAD;
            index_d = temp_sat;
            item_d  = W_OFFSET;
            step_d  = 2'h0;
            last_d  = W_CFG2;
          end
        end
      end
      S_LOAD: begin
        // RL6 two byte reads per word
        // RL4 index-selected entries go to trims
        flash_d.rd   = ~step_q[1];
        flash_d.addr = word_addr + {10'h0, step_q[0]};
        step_d       = step_q + 2'h1;
        if (step_q == 2'h2) begin
          low_d = flash_data_i;
        end
        if (step_q == 2'h3) begin
          words_d[item_q] = {flash_data_i, low_q};
          if (item_q == last_q) begin
            st_d   = S_RUN;
            refr_d = 20'h0;
          end else begin
            item_d = item_q + 3'h1;
          end
        end
      end
      S_RUN: begin
        // RL12 periodic index and trim refresh
        // RL2 new index every refresh period
        if (refr_q >= refr_limit - 20'h1) begin
          st_d    = S_LOAD;
          index_d = temp_sat;
          item_d  = W_OFFSET;
          step_d  = 2'h0;
          last_d  = W_SPAN;
          refr_d  = 20'h0;
        end else if (ctl_write && avs_writedata_i[CTL_RELOAD]) begin
          st_d    = S_LOAD;
          index_d = temp_sat;
          item_d  = W_OFFSET;
          step_d  = 2'h0;
          last_d  = W_CFG2;
        end else begin
          refr_d = refr_q + 20'h1;
        end
      end
      default: st_d = S_LISTEN;
    endcase
  end

  // RL15 window fault gated by enable
  // RL16 clip through all of analog mode, reloads included
  always_comb begin
    analog_d = (st_d == S_LOAD) | (st_d == S_RUN);
    fault_d  = words_q[W_CFG2][FAULT_EN_BIT] & (|sensor_below_i | |sensor_above_i);
    clip_d   = analog_q & fault_q;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st_q     <= S_LISTEN;
      item_q   <= 3'h0;
      step_q   <= 2'h0;
      last_q   <= 3'h0;
      low_q    <= 8'h0;
      words_q  <= '0;
      index_q  <= 8'h0;
      refr_q   <= 20'h0;
      listen_q <= 20'h0;
      data_q   <= 16'h0;
      flash_q  <= '0;
      fault_q  <= 1'b0;
      clip_q   <= 1'b0;
      analog_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      item_q   <= item_d;
      step_q   <= step_d;
      last_q   <= last_d;
      low_q    <= low_d;
      words_q  <= words_d;
      index_q  <= index_d;
      refr_q   <= refr_d;
      listen_q <= listen_d;
      data_q   <= data_d;
      flash_q  <= flash_d;
      fault_q  <= fault_d;
      clip_q   <= clip_d;
      analog_q <= analog_d;
    end
  end

  // ----------------------------------------------------------------
  // auto-baud serial receiver
  // ----------------------------------------------------------------
  // RL19 receiver held idle outside digital mode
  assign rx_en    = (st_q == S_LISTEN) | (st_q == S_CAL);
  assign pin_fall = pin_q & ~shared_output_pin_i;
  assign pin_rise = ~pin_q & shared_output_pin_i;

  always_comb begin
    rx_d        = rx_q;
    cnt_d       = cnt_q + 20'h1;
    period_d    = period_q;
    bit_d       = bit_q;
    shift_d     = shift_q;
    cmd_d       = cmd_q;
    cmd_valid_d = 1'b0;
    rises_d     = rises_q;
    // sticky framing flag, a new error beats the clear
    ferr_d      = ferr_q & ~(ctl_write & avs_writedata_i[CTL_FERR_CLR]);
    if (!rx_en) begin
      rx_d = RX_INIT;
    end else begin
      case (rx_q)
        RX_INIT: if (pin_fall) begin
          rx_d    = RX_MEAS;
          cnt_d   = 20'h1;
          rises_d = 1'b0;
        end
        // RL20 time start edge to stop bit
        // RL18 adopt host rate
        RX_MEAS: if (pin_rise) begin
          if (rises_q) begin
            period_d = 16'(cnt_q / 20'(INIT_SPAN_BITS));
            rx_d     = RX_IDLE;
          end else begin
            rises_d = 1'b1;
          end
        end
        RX_IDLE: if (pin_fall) begin
          rx_d  = RX_START;
          cnt_d = 20'h1;
        end
        RX_START: if (cnt_q == {5'h0, period_q[15:1]}) begin
          rx_d  = shared_output_pin_i ? RX_IDLE : RX_DATA;
          cnt_d = 20'h1;
          bit_d = 3'h0;
        end
        // RL19 eight bits, lsb first
        RX_DATA: if (cnt_q == {4'h0, period_q}) begin
          shift_d = {shared_output_pin_i, shift_q[7:1]};
          cnt_d   = 20'h1;
          bit_d   = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            rx_d = RX_STOP;
          end
        end
        // RL24 low stop bit discards
        RX_STOP: if (cnt_q == {4'h0, period_q}) begin
          rx_d = RX_IDLE;
          if (shared_output_pin_i) begin
            cmd_valid_d = 1'b1;
            cmd_d       = shift_q;
          end else begin
            ferr_d = 1'b1;
          end
        end
        default: rx_d = RX_INIT;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rx_q        <= RX_INIT;
      cnt_q       <= 20'h0;
      period_q    <= 16'h0;
      bit_q       <= 3'h0;
      shift_q     <= 8'h0;
      cmd_q       <= 8'h0;
      cmd_valid_q <= 1'b0;
      rises_q     <= 1'b0;
      ferr_q      <= 1'b0;
      pin_q       <= 1'b1;
    end else begin
      rx_q        <= rx_d;
      cnt_q       <= cnt_d;
      period_q    <= period_d;
      bit_q       <= bit_d;
      shift_q     <= shift_d;
      cmd_q       <= cmd_d;
      cmd_valid_q <= cmd_valid_d;
      rises_q     <= rises_d;
      ferr_q      <= ferr_d;
      pin_q       <= shared_output_pin_i;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // receive-only here; the pin driver stays released
  assign shared_output_pin_o    = pin_q;
  assign shared_output_pin_oe_o = clip_q & ~clip_q;
  assign avs_readdata_o         = rdata_q;
  assign avs_waitrequest_o      = wait_q;
  assign flash_o                = flash_q;
  assign calibration_words_o    = calibration_words_t'(words_q);
  assign temperature_table_index_o = index_q;
  // RL17 mirror ratio field
  assign bridge_mirror_ratio_o  = words_q[W_CFG1][MIRROR_LSB +: 2];
  assign analog_mode_o          = analog_q;
  assign fault_o                = fault_q;
  assign clip_o                 = clip_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  property p_index_sat;
    index_q <= INDEX_MAX;
  endproperty
  a_index_sat: assert property (p_index_sat) else $error("index above 0xaf"); // RL3

  property p_clip;
    (analog_q && fault_q) |=> clip_o;
  endproperty
  a_clip: assert property (p_clip) else $error("fault did not clip"); // RL16

  property p_fault_off;
    !words_q[W_CFG2][FAULT_EN_BIT] |=> !fault_o;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault with detect off"); // RL15

  property p_listen_timeout;
    (st_q == S_LISTEN && !pin_fall && listen_q == 20'(LISTEN_CYCLES_P - 1))
      |=> (st_q == S_LOAD && last_q == W_CFG2 && item_q == W_OFFSET);
  endproperty
  a_listen_timeout: assert property (p_listen_timeout) else $error("no full load on timeout"); // RL11

  property p_word_pair;
    (st_q == S_LOAD && step_q == 2'h3 && item_q == W_OFFSET)
      |=> words_q[W_OFFSET] == {$past(flash_data_i), $past(low_q)};
  endproperty
  a_word_pair: assert property (p_word_pair) else $error("word not built from bytes"); // RL6

  property p_span_addr;
    (flash_q.rd && item_q == W_SPAN)
      |-> flash_q.addr[10:1] == SPAN_TABLE_BASE[10:1] + {2'b00, index_q} && flash_q.addr <= SPAN_TABLE_END;
  endproperty
  a_span_addr: assert property (p_span_addr) else $error("bad span table address"); // RL23

  property p_refresh;
    (st_q == S_RUN && refr_q >= refr_limit - 20'h1) |=> (st_q == S_LOAD && last_q == W_SPAN) ##4 st_q == S_LOAD;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh did not reload trims"); // RL12

  property p_stop_low;
    (rx_q == RX_STOP && cnt_q == {4'h0, period_q} && !shared_output_pin_i) |=> !cmd_valid_q && ferr_q;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("bad frame accepted"); // RL24

  property p_nibble;
    (st_q == S_CAL && cmd_valid_q && cmd_q[3:0] == 4'h0) |=> data_q[3:0] == $past(cmd_q[7:4]);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble not stored"); // RL22

  property p_rx_quiet;
    (st_q == S_RUN) |-> (rx_q == RX_INIT && !cmd_valid_q);
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("serial active in analog mode"); // RL19

endmodule // temp_indexed_cal_loader

`default_nettype wire

// File: cal_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// host calibration tester on the shared serial pin
// ----------------------------------------------------------------
module cal_host_model #(
  parameter int unsigned BIT_CYCLES = 520
) (
  input  wire logic clock_i,
  output logic      line_o
);
  // line rests high between characters, like its pull-up
  initial line_o = 1'b1;

  // one character, start bit first; stop_ok low forces a framing fault
  task automatic send(input logic [7:0] b, input logic stop_ok);
    logic [9:0] frame;
    frame = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_i) line_o <= frame[i];
      repeat (BIT_CYCLES - 1) @(posedge clock_i);
    end
    // one idle bit so a bad stop still ends on a rising edge
    @(posedge clock_i) line_o <= 1'b1;
    repeat (BIT_CYCLES - 1) @(posedge clock_i);
  endtask
endmodule // cal_host_model

`default_nettype wire

// File: test_temp_indexed_cal_loader.sv
`timescale 1ns/1ps
`default_nettype none

module test_temp_indexed_cal_loader import cal_loader_pkg::*;;
  typedef struct {logic signed [9:0] t; logic [7:0] idx;} row_t;
  logic               clock_i, rst_b_i, avs_read_i, avs_write_i, shared_output_pin_o, shared_output_pin_oe_o;
  logic               avs_waitrequest_o, analog_mode_o, fault_o, clip_o, host_line;
  logic [7:0]         avs_address_i, flash_data_i, temperature_table_index_o;
  logic [31:0]        avs_writedata_i, avs_readdata_o, d;
  logic signed [9:0]  temp_code_i;
  logic [1:0]         sensor_below_i, sensor_above_i, bridge_mirror_ratio_o;
  flash_req_t         flash_o;
  calibration_words_t calibration_words_o;
  wire logic          shared_output_pin_i;
  int                 fail_count, comparisons;
  row_t rows[5] = '{'{-10'sd5, 8'h00}, '{10'sd0, 8'h00}, '{10'sd100, 8'h64}, '{10'sd175, 8'haf}, '{10'sd176, 8'haf}};
  logic [7:0] cmds[5] = '{8'hf0, 8'he1, 8'he2, 8'hb3, 8'h04};

  // wire level: device enable wins, else the host drives
  assign shared_output_pin_i = shared_output_pin_oe_o ? shared_output_pin_o : host_line;

  temp_indexed_cal_loader #(.REFRESH_CYCLES_P(64), .LISTEN_CYCLES_P(2000)) DUT (.clock_i, .rst_b_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .shared_output_pin_i,
    .shared_output_pin_o, .shared_output_pin_oe_o, .temp_code_i, .sensor_below_i, .sensor_above_i, .flash_data_i,
    .flash_o, .calibration_words_o, .temperature_table_index_o, .bridge_mirror_ratio_o, .analog_mode_o, .fault_o,
    .clip_o);
  cal_host_model host (.clock_i(clock_i), .line_o(host_line));

  // flash contents: address-derived so a wrong address shows
  function automatic logic [7:0] fb(input logic [10:0] a);
    return a[7:0] ^ {5'h0, a[10:8]} ^ 8'h40;
  endfunction
  function automatic logic [15:0] fw(input logic [10:0] a);
    return {fb(a + 11'h1), fb(a)};
  endfunction
  // byte answer lands one cycle after the strobe
  always_ff @(posedge clock_i) flash_data_i <= fb(flash_o.addr);

  // free-running 20 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic wait_analog();
    int n;
    for (n = 0; n < 5000 && analog_mode_o !== 1'b1; n++) @(posedge clock_i);
    if (n >= 5000) begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic chk_trims(input logic [7:0] idx);
    chk("index", 32'(idx), 32'(temperature_table_index_o));
    chk("offset", 32'(fw(OFFSET_TABLE_BASE + 11'({idx, 1'b0}))), 32'(calibration_words_o.offset_trim_word));
    chk("span", 32'(fw(SPAN_TABLE_BASE + 11'({idx, 1'b0}))), 32'(calibration_words_o.span_trim_word));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    rst_b_i = 1'b0;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {sensor_below_i, sensor_above_i} = '0;
    temp_code_i = 10'sd300;
    repeat (2) @(posedge clock_i);
    chk("wait_rst", 32'h1, 32'(avs_waitrequest_o));
    chk("mode_rst", 32'h0, 32'(analog_mode_o));
    rst_b_i <= 1'b1;
    wait_analog();
    repeat (40) @(posedge clock_i);
    chk_trims(8'haf);
    chk("off_tc", 32'(fw(OFFSET_TC_ADDR)), 32'(calibration_words_o.offset_tempco_word));
    chk("span_tc", 32'(fw(SPAN_TC_ADDR)), 32'(calibration_words_o.span_tempco_word));
    chk("cfg1", 32'(fw(FIRST_CONFIG_WORD_ADDR)), 32'(calibration_words_o.first_config_word));
    chk("cfg2", 32'(fw(SECOND_CONFIG_WORD_ADDR)), 32'(calibration_words_o.second_config_word));
    chk("mirror", 32'(fb(FIRST_CONFIG_WORD_ADDR) & 8'h3), 32'(bridge_mirror_ratio_o));
    $display("test listen_timeout done");
    // each row: new temperature, then wait out a few refresh periods
    foreach (rows[i]) begin
      temp_code_i <= rows[i].t;
      repeat (200) @(posedge clock_i);
      chk_trims(rows[i].idx);
    end
    $display("test refresh_rows done");
    sensor_below_i <= 2'b01;
    for (n = 0; n < 80 && clip_o !== 1'b1; n++) @(posedge clock_i);
    chk("fault_lo", 32'h1, 32'(fault_o));
    chk("clip", 32'h1, 32'(clip_o));
    // clip must ride through the refresh reloads as well
    for (n = 0; n < 80 && clip_o === 1'b1; n++) @(posedge clock_i);
    chk("clip_hold", 32'd80, 32'(n));
    bus(1'b0, REG_STATUS, 32'h0, d);
    chk("status", {16'h0, 8'haf, 8'h05}, d & ~32'h8);
    sensor_below_i <= 2'b00;
    sensor_above_i <= 2'b10;
    repeat (4) @(posedge clock_i);
    chk("fault_hi", 32'h1, 32'(fault_o));
    sensor_above_i <= 2'b00;
    repeat (4) @(posedge clock_i);
    chk("fault_off", 32'h0, 32'(fault_o));
    bus(1'b0, REG_TRIMS, 32'h0, d);
    chk("trims_rd", {fw(11'h35e), fw(11'h15e)}, d);
    bus(1'b0, 8'h40, 32'h0, d);
    chk("unmapped", 32'h0, d);
    $display("test fault_bus done");
    // second power-up: host speaks while the device listens
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    sensor_below_i <= 2'b10;
    repeat (100) @(posedge clock_i); // host idles before the init byte
    chk("fault_dis", 32'h0, 32'(fault_o));
    sensor_below_i <= 2'b00;
    host.send(8'h01, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0, d);
    chk("cal_mode", 32'h2, 32'(d[1:0]));
    bus(1'b1, REG_CONTROL, 32'h0e, d); // page 3 spares the reserved bytes
    for (n = 0; n < 10 && flash_o.erase !== 1'b1; n++) @(posedge clock_i);
    chk("erase_page", 32'h3, 32'(flash_o.page));
    foreach (cmds[i]) host.send(cmds[i], 1'b1);
    chk("ser_word", 32'hbeef, 32'(calibration_words_o.offset_trim_word));
    host.send(8'h50, 1'b0);
    host.send(8'h04, 1'b1);
    chk("ferr_word", 32'hbeef, 32'(calibration_words_o.offset_trim_word));
    bus(1'b0, REG_STATUS, 32'h0, d);
    chk("ferr_flag", 32'h1, 32'(d[4]));
    bus(1'b1, REG_CONTROL, 32'h10, d);
    bus(1'b0, REG_STATUS, 32'h0, d);
    chk("ferr_clr", 32'h0, 32'(d[4]));
    host.send(8'h05, 1'b1);
    wait_analog();
    repeat (40) @(posedge clock_i);
    chk_trims(8'haf);
    bus(1'b0, REG_CONFIG, 32'h0, d);
    chk("cfg_rd", {fw(SECOND_CONFIG_WORD_ADDR), fw(FIRST_CONFIG_WORD_ADDR)}, d);
    $display("test serial_cal done");
    stop_test();
  end
endmodule // test_temp_indexed_cal_loader

`default_nettype wire
